/* File: hw/lpci_pkg.sv */
package lpci_pkg;
  // link clock rates that the capture logic must serve
  localparam int LINK_FAST_MHZ = 33;
  localparam int LINK_SLOW_MHZ = 24;
  localparam int AXI_AW = 8;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_IO_WIN = 8'h04;
  localparam logic [7:0] OFS_MEM_WIN = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_ARRAY = 8'h40;
  // control and status field positions and reset values
  localparam int CTRL_W = 4;
  localparam int CTRL_HS_BIT = 0;
  localparam int CTRL_WAKE_BIT = 1;
  localparam int CTRL_IO_EN_BIT = 2;
  localparam int CTRL_MEM_EN_BIT = 3;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [15:0] IO_BASE_RST = 16'h0000;
  localparam logic [31:0] MEM_BASE_RST = 32'h00000000;
  localparam int STAT_ERR_BIT = 0;
  localparam int STAT_LRST_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;
  // link nibble codes and counts; AXI response codes
  localparam logic [3:0] LAD_START = 4'h0;
  localparam logic [3:0] LAD_SYNC_READY = 4'h0;
  localparam logic [3:0] LAD_SYNC_LWAIT = 4'h6;
  localparam logic [3:0] LAD_TAR = 4'hF;
  localparam logic [1:0] CYC_SPACE_IO = 2'h0;
  localparam logic [1:0] CYC_SPACE_MEM = 2'h1;
  localparam logic [2:0] IO_ADDR_LAST = 3'h3;
  localparam logic [2:0] MEM_ADDR_LAST = 3'h7;
  localparam logic [2:0] TWO_NIB_LAST = 3'h1;
  localparam logic [2:0] SYNC_MIN_WAIT = 3'h2;
  localparam logic [2:0] SYNC_HS_EXTRA = 3'h1;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_CYCT = 9'h002,
    ST_ADDR = 9'h004,
    ST_WDAT = 9'h008,
    ST_HTAR = 9'h010,
    ST_SYNC = 9'h020,
    ST_RDAT = 9'h040,
    ST_DTAR = 9'h080,
    ST_SKIP = 9'h100
  } lpci_state_t;
endpackage

/* File: hw/lpci_core.sv */
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
// Function
// RULE_01 - link logic on bus clock, handshake option
// RULE_02 - power-on reset clears everything; the storage array arr_q is not cleared
// RULE_03 - bus reset clears its own subset
// RULE_04 - main-power reset clears windows only
// RULE_05 - new cycle accepted right after bus reset
// RULE_06 - power-on reset released before host traffic
// RULE_07 - bus pins float during any reset
// RULE_08 - fully working in light sleep states
// RULE_09 - bus pins float in deep sleep
// RULE_10 - bus traffic raises wake event
// RULE_11 - error event follows error status bit zero
// RULE_12 - drop clock request only when idle
// RULE_13 - traffic after sleep pulses wake
// RULE_14 - claim only cycles hitting own windows
// RULE_15 - single-byte io and memory cycles only
// RULE_16 - memory cycles reach internal storage
// RULE_17 - host powers down bus cleanly
// RULE_18 - two long waits minimum, no error sync
// RULE_19 - host sends only supported cycles
module lpci_core #(
  parameter int ARRAY_AW = 4
) (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic LCLK_I,
  input wire logic LRESET_N_I,
  input wire logic LFRAME_N_I,
  input wire logic LPCPD_N_I,
  input wire logic [3:0] LAD_I,
  output logic [3:0] LAD_O,
  output logic LAD_OE_O,
  output logic SERIRQ_O,
  output logic SERIRQ_OE_O,
  output logic CLKRUN_N_O,
  output logic CLKRUN_N_OE_O,
  input wire logic MAIN_POWER_RESET_N_I,
  input wire logic DEEP_SLEEP_I,
  input wire logic SLEEP_REQ_I,
  output logic CLK_REQ_O,
  output logic BUS_TRAFFIC_WAKE_O,
  output logic BUS_INTERNAL_ERROR_EVENT_O
);
  localparam int DEPTH = 1 << ARRAY_AW;

  initial begin
    if (ARRAY_AW < 1 || ARRAY_AW > 4) begin
      $error("ARRAY_AW must be 1 to 4");
    end
  end

  function automatic logic is_array(input logic [7:0] a);
    is_array = (a[7:ARRAY_AW+2] == lpci_pkg::OFS_ARRAY[7:ARRAY_AW+2]);
  endfunction

  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] d,
                                             input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    apply_strb = (old & ~m) | (d & m);
  endfunction

  // ---------------- crossings ----------------
  localparam int CS_LRST = 0;
  localparam int CS_MPWR = 1;
  localparam int CS_BUSY = 2;
  localparam int CS_START = 3;
  localparam int CS_ERR = 4;
  localparam int CS_REQ = 5;
  localparam int CS_CFGACK = 6;
  localparam int LS_POR = 0;
  localparam int LS_DEEP = 1;
  localparam int LS_MPWR = 2;
  localparam int LS_ACK = 3;
  localparam int LS_CFGREQ = 4;

  logic busy_l_q, start_t_q, err_t_q, req_q, cfg_ack_q;
  logic ack_c_q, cfg_req_q;
  logic [6:0] c_s1_q, c_s2_q;
  logic [4:0] l_s1_q, l_s2_q;
  wire [6:0] c_async = {cfg_ack_q, req_q, err_t_q, start_t_q, busy_l_q, MAIN_POWER_RESET_N_I,
                        LRESET_N_I};
  wire [4:0] l_async = {cfg_req_q, ack_c_q, MAIN_POWER_RESET_N_I, DEEP_SLEEP_I, SYS_RST_I};

  always_ff @(posedge CLK_I) begin
    c_s1_q <= c_async;
    c_s2_q <= c_s1_q;
  end

  always_ff @(posedge LCLK_I) begin
    l_s1_q <= l_async;
    l_s2_q <= l_s1_q;
  end

  // ---------------- link domain ----------------
  lpci_pkg::lpci_state_t st_q;
  logic [2:0] cnt_q, wait_q;
  logic mem_q, wr_q, sent_q;
  logic [31:0] addr_q;
  logic [7:0] wdat_q;
  logic [7:0] rdata_c_q;
  logic [51:0] cfg_snap_q, cfg_l_q;

  // the host's reset is applied as soon as the pin drops; power-on crosses first
  wire por_l = l_s2_q[LS_POR]; // RULE_06
  wire link_rst = por_l || !LRESET_N_I; // RULE_02 RULE_03
  wire deep_l = l_s2_q[LS_DEEP];
  wire hiz_l = link_rst || !l_s2_q[LS_MPWR] || !LPCPD_N_I || deep_l; // RULE_07 RULE_09 RULE_17
  wire [3:0] cfg_ctrl_l = cfg_l_q[51:48];
  wire [15:0] io_base_l = cfg_l_q[47:32];
  wire [31:0] mem_base_l = cfg_l_q[31:0];
  wire [31:0] addr_nxt = {addr_q[27:0], LAD_I};
  wire claim_io = cfg_ctrl_l[lpci_pkg::CTRL_IO_EN_BIT] && !mem_q &&
                  (addr_nxt[15:ARRAY_AW] == io_base_l[15:ARRAY_AW]); // RULE_14
  wire claim_mem = cfg_ctrl_l[lpci_pkg::CTRL_MEM_EN_BIT] && mem_q &&
                   (addr_nxt[31:ARRAY_AW] == mem_base_l[31:ARRAY_AW]); // RULE_14 RULE_16
  wire cyc_ok = (LAD_I[3:2] == lpci_pkg::CYC_SPACE_IO) ||
                (LAD_I[3:2] == lpci_pkg::CYC_SPACE_MEM); // RULE_15
  wire pending_l = (req_q != l_s2_q[LS_ACK]);
  wire req_fire = !link_rst && LFRAME_N_I && (st_q == lpci_pkg::ST_SYNC) &&
                  !sent_q && !pending_l;
  // slow bus clock gets one more wait to let the crossing settle
  wire [2:0] min_wait = lpci_pkg::SYNC_MIN_WAIT +
                        (cfg_ctrl_l[lpci_pkg::CTRL_HS_BIT] ? lpci_pkg::SYNC_HS_EXTRA : 3'h0); // RULE_01
  wire sync_done = sent_q && !pending_l && (wait_q >= min_wait); // RULE_18
  wire in_claimed = (st_q == lpci_pkg::ST_WDAT) || (st_q == lpci_pkg::ST_HTAR) ||
                    (st_q == lpci_pkg::ST_SYNC) || (st_q == lpci_pkg::ST_RDAT);
  wire [3:0] rd_nib = cnt_q[0] ? rdata_c_q[3:0] : rdata_c_q[7:4];
  wire lad_drive = (st_q == lpci_pkg::ST_SYNC) || (st_q == lpci_pkg::ST_RDAT) ||
                   ((st_q == lpci_pkg::ST_DTAR) && cnt_q[0]);

  assign LAD_OE_O = lad_drive && !hiz_l; // RULE_07 RULE_09 RULE_08
  assign LAD_O = (st_q == lpci_pkg::ST_SYNC) ?
                 (sync_done ? lpci_pkg::LAD_SYNC_READY : lpci_pkg::LAD_SYNC_LWAIT) :
                 (st_q == lpci_pkg::ST_RDAT) ? rd_nib : lpci_pkg::LAD_TAR; // RULE_18
  // interrupt serialiser and clock-run are not driven by this core
  assign SERIRQ_O = 1'b0;
  assign SERIRQ_OE_O = 1'b0; // RULE_07
  assign CLKRUN_N_O = 1'b0;
  assign CLKRUN_N_OE_O = 1'b0; // RULE_07

  always_ff @(posedge LCLK_I) begin
    if (link_rst) begin
      st_q <= lpci_pkg::ST_IDLE; // RULE_05
      cnt_q <= 3'h0;
      wait_q <= 3'h0;
      mem_q <= 1'b0;
      wr_q <= 1'b0;
      sent_q <= 1'b0;
      addr_q <= 32'h00000000;
      wdat_q <= 8'h00;
      start_t_q <= 1'b0;
      err_t_q <= 1'b0;
    end else if (!LFRAME_N_I) begin
      // frame low always restarts; a claimed cycle cut short is an error
      st_q <= (LAD_I == lpci_pkg::LAD_START) ? lpci_pkg::ST_CYCT : lpci_pkg::ST_IDLE;
      if (LAD_I == lpci_pkg::LAD_START) begin
        start_t_q <= ~start_t_q; // RULE_10
      end
      if (in_claimed) begin
        err_t_q <= ~err_t_q; // RULE_11
      end
    end else begin
      unique case (st_q)
        lpci_pkg::ST_IDLE: st_q <= lpci_pkg::ST_IDLE;
        lpci_pkg::ST_CYCT: begin
          mem_q <= LAD_I[2];
          wr_q <= LAD_I[1];
          addr_q <= 32'h00000000;
          cnt_q <= LAD_I[2] ? lpci_pkg::MEM_ADDR_LAST : lpci_pkg::IO_ADDR_LAST;
          st_q <= cyc_ok ? lpci_pkg::ST_ADDR : lpci_pkg::ST_SKIP; // RULE_15 RULE_19
        end
        lpci_pkg::ST_ADDR: begin
          addr_q <= addr_nxt;
          cnt_q <= cnt_q - 3'h1;
          if (cnt_q == 3'h0) begin
            cnt_q <= lpci_pkg::TWO_NIB_LAST;
            if (claim_io || claim_mem) begin
              st_q <= wr_q ? lpci_pkg::ST_WDAT : lpci_pkg::ST_HTAR;
            end else begin
              st_q <= lpci_pkg::ST_SKIP; // RULE_14
            end
          end
        end
        lpci_pkg::ST_WDAT: begin
          wdat_q <= {LAD_I, wdat_q[7:4]};
          cnt_q <= cnt_q - 3'h1;
          if (cnt_q == 3'h0) begin
            cnt_q <= lpci_pkg::TWO_NIB_LAST;
            st_q <= lpci_pkg::ST_HTAR;
          end
        end
        lpci_pkg::ST_HTAR: begin
          cnt_q <= cnt_q - 3'h1;
          if (cnt_q == 3'h0) begin
            st_q <= lpci_pkg::ST_SYNC;
            wait_q <= 3'h0;
            sent_q <= 1'b0;
          end
        end
        lpci_pkg::ST_SYNC: begin
          // an aborted access may still be in service; wait for its answer first
          if (req_fire) begin
            sent_q <= 1'b1;
          end
          if (wait_q != 3'h7) begin
            wait_q <= wait_q + 3'h1;
          end
          if (sync_done) begin
            cnt_q <= lpci_pkg::TWO_NIB_LAST;
            st_q <= wr_q ? lpci_pkg::ST_DTAR : lpci_pkg::ST_RDAT;
          end
        end
        lpci_pkg::ST_RDAT: begin
          cnt_q <= cnt_q - 3'h1;
          if (cnt_q == 3'h0) begin
            cnt_q <= lpci_pkg::TWO_NIB_LAST;
            st_q <= lpci_pkg::ST_DTAR;
          end
        end
        lpci_pkg::ST_DTAR: begin
          cnt_q <= cnt_q - 3'h1;
          if (cnt_q == 3'h0) begin
            st_q <= lpci_pkg::ST_IDLE;
          end
        end
        lpci_pkg::ST_SKIP: st_q <= lpci_pkg::ST_SKIP;
        default: st_q <= lpci_pkg::ST_IDLE;
      endcase
    end
  end

  // request toggle survives the bus reset so the handshake never desynchronises
  always_ff @(posedge LCLK_I) begin
    if (por_l) begin
      req_q <= 1'b0;
      cfg_ack_q <= 1'b0;
      cfg_l_q <= {lpci_pkg::CTRL_RST, lpci_pkg::IO_BASE_RST, lpci_pkg::MEM_BASE_RST};
      busy_l_q <= 1'b0;
    end else begin
      busy_l_q <= (st_q != lpci_pkg::ST_IDLE) && (st_q != lpci_pkg::ST_SKIP);
      if (req_fire) begin
        req_q <= ~req_q;
      end
      if (l_s2_q[LS_CFGREQ] != cfg_ack_q) begin
        cfg_l_q <= cfg_snap_q;
        cfg_ack_q <= l_s2_q[LS_CFGREQ];
      end
    end
  end

  a_tristate_reset: assert property (@(posedge LCLK_I) disable iff (por_l)
    (!LRESET_N_I || !LPCPD_N_I) |-> !LAD_OE_O && !SERIRQ_OE_O && !CLKRUN_N_OE_O) // RULE_07
    else $error("bus pins driven during reset or power-down");
  a_sync_two_waits: assert property (@(posedge LCLK_I) disable iff (link_rst)
    ($rose(st_q == lpci_pkg::ST_SYNC) && !hiz_l) |-> (LAD_O == lpci_pkg::LAD_SYNC_LWAIT)
    ##1 (!LFRAME_N_I || LAD_O == lpci_pkg::LAD_SYNC_LWAIT)) // RULE_18
    else $error("fewer than two long waits");
  a_sync_no_error: assert property (@(posedge LCLK_I) disable iff (link_rst)
    (st_q == lpci_pkg::ST_SYNC) |->
    (LAD_O == lpci_pkg::LAD_SYNC_READY || LAD_O == lpci_pkg::LAD_SYNC_LWAIT)) // RULE_18
    else $error("illegal sync code");
  a_deep_sleep_hiz: assert property (@(posedge LCLK_I) disable iff (link_rst)
    deep_l |-> !LAD_OE_O) // RULE_09
    else $error("bus driven in deep sleep");
  a_bad_cycle_skip: assert property (@(posedge LCLK_I) disable iff (link_rst)
    (st_q == lpci_pkg::ST_CYCT && LFRAME_N_I && LAD_I[3]) |=>
    (st_q == lpci_pkg::ST_SKIP) [*1] ##1 !LAD_OE_O) // RULE_15
    else $error("unsupported cycle not ignored");
  a_unclaimed_quiet: assert property (@(posedge LCLK_I) disable iff (link_rst)
    (st_q == lpci_pkg::ST_ADDR && cnt_q == 3'h0 && LFRAME_N_I && !claim_io && !claim_mem)
    |=> !LAD_OE_O [*3]) // RULE_14
    else $error("unclaimed cycle answered");
  a_lreset_ready: assert property (@(posedge LCLK_I) disable iff (por_l)
    $fell(link_rst) |-> (st_q == lpci_pkg::ST_IDLE)) // RULE_05
    else $error("not idle after bus reset");

  // ---------------- system domain ----------------
  localparam int CTRL_W_L = lpci_pkg::CTRL_W;
  logic [CTRL_W_L-1:0] ctrl_q;
  logic [15:0] io_base_q;
  logic [31:0] mem_base_q;
  logic err_q, cfg_dirty_q, wake_q;
  logic start_p_q, err_p_q;
  logic aw_held_q, w_held_q, bvalid_q, rvalid_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q, rdata_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [7:0] arr_q [DEPTH];

  wire mp_rst = !c_s2_q[CS_MPWR];
  wire lrst_c = !c_s2_q[CS_LRST];
  wire start_edge = c_s2_q[CS_START] != start_p_q;
  wire err_edge = c_s2_q[CS_ERR] != err_p_q;
  wire svc_pend = c_s2_q[CS_REQ] != ack_c_q;
  wire busy_c = c_s2_q[CS_BUSY] || svc_pend;
  wire cfg_send = cfg_dirty_q && (cfg_req_q == c_s2_q[CS_CFGACK]);

  wire wr_go = aw_held_q && w_held_q && !bvalid_q;
  wire wr_ctrl = wr_go && (aw_addr_q == lpci_pkg::OFS_CTRL);
  wire wr_io = wr_go && (aw_addr_q == lpci_pkg::OFS_IO_WIN);
  wire wr_mem = wr_go && (aw_addr_q == lpci_pkg::OFS_MEM_WIN);
  wire wr_stat = wr_go && (aw_addr_q == lpci_pkg::OFS_STATUS);
  wire wr_arr = wr_go && is_array(aw_addr_q);
  wire wr_ok = wr_ctrl || wr_io || wr_mem || wr_stat || wr_arr;
  wire [31:0] m_ctrl = apply_strb({28'h0000000, ctrl_q}, w_data_q, w_strb_q);
  wire [31:0] m_io = apply_strb({16'h0000, io_base_q}, w_data_q, w_strb_q);
  wire [31:0] m_mem = apply_strb(mem_base_q, w_data_q, w_strb_q);
  wire err_clr = wr_stat && w_strb_q[0] && w_data_q[lpci_pkg::STAT_ERR_BIT];

  wire [7:0] ar = S_AXI_ARADDR_I;
  wire ar_arr = is_array(ar);
  wire [31:0] stat_word = {29'h00000000, busy_c, lrst_c, err_q};
  wire [31:0] rd_word = (ar == lpci_pkg::OFS_CTRL) ? {28'h0000000, ctrl_q} :
                        (ar == lpci_pkg::OFS_IO_WIN) ? {16'h0000, io_base_q} :
                        (ar == lpci_pkg::OFS_MEM_WIN) ? mem_base_q :
                        (ar == lpci_pkg::OFS_STATUS) ? stat_word :
                        ar_arr ? {24'h000000, arr_q[ar[ARRAY_AW+1:2]]} : 32'h00000000;
  wire rd_ok = (ar == lpci_pkg::OFS_CTRL) || (ar == lpci_pkg::OFS_IO_WIN) ||
               (ar == lpci_pkg::OFS_MEM_WIN) || (ar == lpci_pkg::OFS_STATUS) || ar_arr;

  assign S_AXI_AWREADY_O = !aw_held_q && !bvalid_q;
  assign S_AXI_WREADY_O = !w_held_q && !bvalid_q;
  assign S_AXI_BVALID_O = bvalid_q;
  assign S_AXI_BRESP_O = bresp_q;
  assign S_AXI_ARREADY_O = !rvalid_q;
  assign S_AXI_RVALID_O = rvalid_q;
  assign S_AXI_RDATA_O = rdata_q;
  assign S_AXI_RRESP_O = rresp_q;
  assign CLK_REQ_O = !(SLEEP_REQ_I && !busy_c); // RULE_12
  assign BUS_TRAFFIC_WAKE_O = wake_q;
  assign BUS_INTERNAL_ERROR_EVENT_O = err_q; // RULE_11

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      bresp_q <= lpci_pkg::AXI_OKAY;
      rdata_q <= 32'h00000000;
      rresp_q <= lpci_pkg::AXI_OKAY;
    end else begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        w_held_q <= 1'b1;
        w_data_q <= S_AXI_WDATA_I;
        w_strb_q <= S_AXI_WSTRB_I;
      end
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? lpci_pkg::AXI_OKAY : lpci_pkg::AXI_SLVERR;
      end else if (S_AXI_BREADY_I) begin
        bvalid_q <= 1'b0;
      end
      if (S_AXI_ARVALID_I && !rvalid_q) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_word;
        rresp_q <= rd_ok ? lpci_pkg::AXI_OKAY : lpci_pkg::AXI_SLVERR;
      end else if (S_AXI_RREADY_I) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      ctrl_q <= lpci_pkg::CTRL_RST; // RULE_02
      start_p_q <= 1'b0;
      err_p_q <= 1'b0;
      wake_q <= 1'b0;
      ack_c_q <= 1'b0;
      cfg_req_q <= 1'b0;
      rdata_c_q <= 8'h00;
    end else begin
      start_p_q <= c_s2_q[CS_START];
      err_p_q <= c_s2_q[CS_ERR];
      wake_q <= start_edge && !CLK_REQ_O && ctrl_q[lpci_pkg::CTRL_WAKE_BIT]; // RULE_10 RULE_13
      if (wr_ctrl) begin
        ctrl_q <= m_ctrl[CTRL_W_L-1:0];
      end
      if (cfg_send) begin
        cfg_req_q <= ~cfg_req_q;
      end
      // register writes win the array port; the link access waits one cycle
      if (svc_pend && !wr_arr) begin
        ack_c_q <= c_s2_q[CS_REQ];
        if (!wr_q) begin
          rdata_c_q <= arr_q[addr_q[ARRAY_AW-1:0]]; // RULE_16
        end
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (wr_arr && w_strb_q[0]) begin
      arr_q[aw_addr_q[ARRAY_AW+1:2]] <= w_data_q[7:0];
    end else if (svc_pend && wr_q) begin
      arr_q[addr_q[ARRAY_AW-1:0]] <= wdat_q; // RULE_15
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I || mp_rst) begin
      io_base_q <= lpci_pkg::IO_BASE_RST; // RULE_04
      mem_base_q <= lpci_pkg::MEM_BASE_RST;
      cfg_dirty_q <= 1'b1;
      cfg_snap_q <= {lpci_pkg::CTRL_RST, lpci_pkg::IO_BASE_RST, lpci_pkg::MEM_BASE_RST};
    end else begin
      if (wr_io) begin
        io_base_q <= m_io[15:0];
      end
      if (wr_mem) begin
        mem_base_q <= m_mem;
      end
      if (cfg_send) begin
        cfg_snap_q <= {ctrl_q, io_base_q, mem_base_q};
      end
      // a write landing during a send marks the snapshot stale again
      cfg_dirty_q <= wr_ctrl || wr_io || wr_mem || (cfg_dirty_q && !cfg_send);
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I || lrst_c) begin
      err_q <= 1'b0; // RULE_02 RULE_03
    end else if (err_edge) begin
      err_q <= 1'b1; // RULE_11
    end else if (err_clr) begin
      err_q <= 1'b0;
    end
  end

  a_clkreq_busy: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (SLEEP_REQ_I && c_s2_q[CS_BUSY]) |-> CLK_REQ_O ##1 (CLK_REQ_O || !c_s2_q[CS_BUSY])) // RULE_12
    else $error("clock request dropped while busy");
  a_wake_traffic: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (start_edge && !CLK_REQ_O && ctrl_q[lpci_pkg::CTRL_WAKE_BIT]) |=> BUS_TRAFFIC_WAKE_O
    ##1 !BUS_TRAFFIC_WAKE_O || start_edge) // RULE_13
    else $error("no wake after traffic in sleep");
  a_err_sticky: assert property (@(posedge CLK_I) disable iff (SYS_RST_I || lrst_c)
    err_edge |=> BUS_INTERNAL_ERROR_EVENT_O) // RULE_11
    else $error("error event not raised");
  a_por_defaults: assert property (@(posedge CLK_I)
    SYS_RST_I |=> (ctrl_q == lpci_pkg::CTRL_RST) && !err_q &&
    (io_base_q == lpci_pkg::IO_BASE_RST) && !bvalid_q && !rvalid_q) // RULE_02
    else $error("defaults not restored by power-on reset");
  a_mainpwr_subset: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (mp_rst && !wr_ctrl) |=> (io_base_q == lpci_pkg::IO_BASE_RST) &&
    (mem_base_q == lpci_pkg::MEM_BASE_RST) && $stable(ctrl_q)) // RULE_04
    else $error("main-power reset scope wrong");
  a_busrst_err: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    lrst_c |=> !err_q && ($stable(io_base_q) || $past(mp_rst) || $past(wr_io))) // RULE_03
    else $error("bus reset scope wrong");
endmodule // lpci_core

/* File: verification/lpci_host_model.sv */
`timescale 1ns/1ps
module lpci_host_model (
  input wire logic lclk_i,
  input wire logic [3:0] lad_i,
  input wire logic dev_oe_i,
  output logic lframe_n_o = 1'b1,
  output logic [3:0] lad_o = 4'hF,
  output logic lad_oe_o = 1'b0
);
  task automatic drv(input logic f, input logic [3:0] v);
    @(posedge lclk_i);
    lframe_n_o <= f;
    lad_o <= v;
    lad_oe_o <= 1'b1;
  endtask
  // one single-byte frame; ab aborts it after the first wait sync
  task automatic run(input logic [3:0] ct, input int na, input logic [31:0] a,
      input logic [7:0] wd, input bit ab, output logic [7:0] rd, output int ws,
      output bit dv);
    int n;
    rd = 8'h00;
    ws = 0;
    dv = 0;
    drv(1'b0, 4'h0);
    drv(1'b1, ct);
    for (n = na - 1; n >= 0; n--) drv(1'b1, a[4*n+:4]);
    if (ct[1]) drv(1'b1, wd[3:0]);
    if (ct[1]) drv(1'b1, wd[7:4]);
    drv(1'b1, 4'hF);
    @(posedge lclk_i);
    lad_oe_o <= 1'b0;
    for (n = 0; n < 40; n++) begin
      @(posedge lclk_i);
      if (dev_oe_i === 1'b1) dv = 1;
      if (dev_oe_i === 1'b1 && lad_i === 4'h6) ws++;
      if (ab && ws == 1) break;
      if (dev_oe_i === 1'b1 && lad_i === 4'h0) break;
    end
    if (ab) drv(1'b0, 4'hF);
    if (dv && !ab && !ct[1]) begin
      @(posedge lclk_i);
      rd[3:0] = lad_i;
      @(posedge lclk_i);
      rd[7:4] = lad_i;
    end
    drv(1'b1, 4'hF);
    @(posedge lclk_i);
    lad_oe_o <= 1'b0;
  endtask
endmodule // lpci_host_model

/* File: verification/test_lpc_peripheral_interface_core.sv */
`timescale 1ns/1ps
module test_lpc_peripheral_interface_core;
  logic clk = 0, rst = 1, lclk = 0, lrst_n = 0, mpr_n = 1, deep = 0, slp = 0, pd_n = 1;
  logic [7:0] awaddr = 0, araddr = 0, rd;
  logic [31:0] wdata = 0, rdata, v;
  logic awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, awrdy, wrdy, bvalid, arrdy;
  logic rvalid, lad_oe, creq, wake, err, h_fr, h_oe, sq_oe, cr_oe;
  logic [1:0] bresp, rresp, r;
  logic [3:0] lad_o, h_lad;
  // released bus floats high through the pull-ups
  wire [3:0] lad_w = lad_oe ? lad_o : (h_oe ? h_lad : 4'hF);
  int fail_count = 0, cmp_count = 0, cyc_n = 0, wk = 0, ws;
  bit dv, creq_hi;
  lpci_core u_lpci_core (.CLK_I(clk), .SYS_RST_I(rst), .S_AXI_AWADDR_I(awaddr),
    .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awrdy), .S_AXI_WDATA_I(wdata),
    .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrdy),
    .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arrdy),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
    .S_AXI_RREADY_I(rready), .LCLK_I(lclk), .LRESET_N_I(lrst_n), .LFRAME_N_I(h_fr),
    .LPCPD_N_I(pd_n), .LAD_I(lad_w), .LAD_O(lad_o), .LAD_OE_O(lad_oe), .SERIRQ_O(),
    .SERIRQ_OE_O(sq_oe), .CLKRUN_N_O(), .CLKRUN_N_OE_O(cr_oe), .MAIN_POWER_RESET_N_I(mpr_n),
    .DEEP_SLEEP_I(deep), .SLEEP_REQ_I(slp), .CLK_REQ_O(creq),
    .BUS_TRAFFIC_WAKE_O(wake), .BUS_INTERNAL_ERROR_EVENT_O(err));
  lpci_host_model u_lpci_host_model (.lclk_i(lclk), .lad_i(lad_w), .dev_oe_i(lad_oe),
    .lframe_n_o(h_fr), .lad_o(h_lad), .lad_oe_o(h_oe));
  initial forever #12.5 clk = ~clk;
  initial begin
    #7;
    forever #32 lclk = ~lclk;
  end
  always @(posedge clk) begin
    cyc_n++;
    if (wake === 1'b1) wk++;
    if (creq === 1'b1) creq_hi = 1;
    if (cyc_n == 60000) begin
      fail_count++;
      conclude();
    end
  end
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", s, e, g);
      fail_count++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1;
    wv <= 1;
    bready <= 1;
    do begin
      @(posedge clk);
      if (awv && awrdy === 1'b1) awv <= 0;
      if (wv && wrdy === 1'b1) wv <= 0;
    end while (bvalid !== 1'b1);
    bready <= 0;
    chk("bresp", 32'(er), 32'(bresp));
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arv <= 1;
    rready <= 1;
    do begin
      @(posedge clk);
      if (arv && arrdy === 1'b1) arv <= 0;
    end while (rvalid !== 1'b1);
    v = rdata;
    r = rresp;
    rready <= 0;
  endtask
  task automatic lpc(input logic [3:0] ct, input logic [31:0] a, input logic [7:0] wd,
      input bit ab);
    u_lpci_host_model.run(ct, ct[2] ? 8 : 4, a, wd, ab, rd, ws, dv);
  endtask
  task automatic t_regs;
    rdr(lpci_pkg::OFS_CTRL);
    chk("ctrl", 32'(lpci_pkg::CTRL_RST), v);
    rdr(lpci_pkg::OFS_MEM_WIN);
    chk("mem_win", lpci_pkg::MEM_BASE_RST, v);
    wr(8'h20, 32'h1, lpci_pkg::AXI_SLVERR);
    rdr(8'h20);
    chk("rresp", 32'(lpci_pkg::AXI_SLVERR), 32'(r));
    wr(lpci_pkg::OFS_IO_WIN, 32'h0300, lpci_pkg::AXI_OKAY);
    wr(lpci_pkg::OFS_MEM_WIN, 32'h00FE0000, lpci_pkg::AXI_OKAY);
    wr(lpci_pkg::OFS_CTRL, 32'hC, lpci_pkg::AXI_OKAY);
    repeat (20) @(posedge clk); // link-side copy of the windows settles
    $display("regs done");
  endtask
  task automatic t_io;
    lpc(4'h2, 32'h0305, 8'hA5, 0);
    chk("io wr waits", 1, 32'(ws >= 2));
    lpc(4'h0, 32'h0305, 8'h00, 0);
    chk("io rd", 8'hA5, 32'(rd));
    lpc(4'h0, 32'h0315, 8'h00, 0);
    chk("other addr", 0, 32'(dv));
    lpc(4'h8, 32'h0305, 8'h00, 0);
    chk("bad type", 0, 32'(dv));
    $display("io done");
  endtask
  task automatic t_mem;
    lpc(4'h6, 32'h00FE0009, 8'h3C, 0);
    lpc(4'h4, 32'h00FE0005, 8'h00, 0);
    chk("mem rd", 8'hA5, 32'(rd));
    rdr(lpci_pkg::OFS_ARRAY + 8'h24);
    chk("array", 32'h3C, v);
    wr(lpci_pkg::OFS_CTRL, 32'hD, lpci_pkg::AXI_OKAY);
    repeat (20) @(posedge clk);
    lpc(4'h0, 32'h0305, 8'h00, 0);
    chk("slow waits", 1, 32'(ws >= 3));
    $display("mem done");
  endtask
  task automatic t_sleep;
    wr(lpci_pkg::OFS_CTRL, 32'hE, lpci_pkg::AXI_OKAY);
    repeat (20) @(posedge clk);
    slp <= 1;
    repeat (4) @(posedge clk);
    chk("clk req idle", 0, 32'(creq));
    creq_hi = 0;
    wk = 0;
    lpc(4'h0, 32'h0305, 8'h00, 0);
    repeat (10) @(posedge clk);
    chk("wake", 1, 32'(wk > 0));
    chk("clk req busy", 1, 32'(creq_hi));
    slp <= 0;
    $display("sleep done");
  endtask
  task automatic t_err;
    lpc(4'h0, 32'h0305, 8'h00, 1);
    repeat (10) @(posedge clk);
    rdr(lpci_pkg::OFS_STATUS);
    chk("err bit", 1, 32'(v[0]));
    chk("err event", 1, 32'(err));
    @(posedge lclk);
    lrst_n <= 0;
    repeat (4) @(posedge lclk);
    chk("oe bus rst", 0, 32'(lad_oe));
    chk("err cleared", 0, 32'(err));
    @(posedge lclk);
    lrst_n <= 1;
    lpc(4'h0, 32'h0305, 8'h00, 0);
    chk("after rst", 8'hA5, 32'(rd));
    $display("error done");
  endtask
  task automatic t_power;
    pd_n <= 0;
    repeat (10) @(posedge clk);
    chk("oe power-down", 0, 32'({lad_oe, sq_oe, cr_oe}));
    pd_n <= 1;
    deep <= 1;
    repeat (10) @(posedge clk);
    lpc(4'h0, 32'h0305, 8'h00, 0);
    chk("deep sleep", 0, 32'(dv));
    deep <= 0;
    mpr_n <= 0;
    repeat (10) @(posedge clk);
    chk("oe main rst", 0, 32'(lad_oe));
    mpr_n <= 1;
    repeat (10) @(posedge clk);
    rdr(lpci_pkg::OFS_IO_WIN);
    chk("io_win", 32'(lpci_pkg::IO_BASE_RST), v);
    rdr(lpci_pkg::OFS_CTRL);
    chk("ctrl kept", 32'hE, v);
    $display("power done");
  endtask
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    chk("oe sys rst", 0, 32'(lad_oe));
    repeat (2) @(posedge clk);
    rst <= 0;
    @(posedge lclk);
    lrst_n <= 1;
    t_regs();
    t_io();
    t_mem();
    t_sleep();
    t_err();
    t_power();
    conclude();
  end
endmodule // test_lpc_peripheral_interface_core
